// file: common/adcc_pkg.sv
`default_nettype none
package adcc_pkg;

    localparam logic [15:0] ADDR_RESULT_LO = 16'hFF08;
    localparam logic [15:0] ADDR_RESULT_HI = 16'hFF09;
    localparam logic [15:0] ADDR_MODE      = 16'hFF28;
    localparam logic [15:0] ADDR_CHANNEL   = 16'hFF29;
    localparam logic [15:0] ADDR_CMP_MODE  = 16'hFF2A;
    localparam logic [15:0] ADDR_THRESHOLD = 16'hFF2B;

    localparam int unsigned MODE_RUN_BIT     = 7;
    localparam int unsigned MODE_TIME_LSB    = 3;
    localparam int unsigned MODE_REFGEN_BIT  = 0;
    localparam int unsigned CMP_ENABLE_BIT   = 7;
    localparam int unsigned CMP_POLARITY_BIT = 6;
    localparam int unsigned RESULT_PAD_BITS  = 6;

    localparam logic [7:0] MODE_RESET      = 8'h00;
    localparam logic [7:0] CHANNEL_RESET   = 8'h00;
    localparam logic [7:0] CMP_MODE_RESET  = 8'h00;
    localparam logic [7:0] THRESHOLD_RESET = 8'h00;

    // Conversion periods in system clocks for each permitted time-select code
    localparam int unsigned CONV_PER_T0 = 288;
    localparam int unsigned CONV_PER_T1 = 240;
    localparam int unsigned CONV_PER_T2 = 192;
    localparam int unsigned CONV_PER_T4 = 144;
    localparam int unsigned CONV_PER_T5 = 120;
    localparam int unsigned CONV_PER_T6 = 96;
    localparam int unsigned CONV_SLOTS   = 12;
    localparam int unsigned SAMPLE_SLOTS = 2;

    localparam logic [7:0] SLOT_CYC_T0 = 8'(CONV_PER_T0 / CONV_SLOTS);
    localparam logic [7:0] SLOT_CYC_T1 = 8'(CONV_PER_T1 / CONV_SLOTS);
    localparam logic [7:0] SLOT_CYC_T2 = 8'(CONV_PER_T2 / CONV_SLOTS);
    localparam logic [7:0] SLOT_CYC_T4 = 8'(CONV_PER_T4 / CONV_SLOTS);
    localparam logic [7:0] SLOT_CYC_T5 = 8'(CONV_PER_T5 / CONV_SLOTS);
    localparam logic [7:0] SLOT_CYC_T6 = 8'(CONV_PER_T6 / CONV_SLOTS);

    typedef enum logic [2:0] {
        TIME_288 = 3'h0,
        TIME_240 = 3'h1,
        TIME_192 = 3'h2,
        TIME_144 = 3'h4,
        TIME_120 = 3'h5,
        TIME_96  = 3'h6
    } adcc_time_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } adcc_state_e;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic        wide;
        logic [15:0] addr;
        logic [7:0]  wrData;
    } adcc_bus_req_s;

    typedef struct packed {
        logic        waitCycle;
        logic        rdValid;
        logic [15:0] rdData;
    } adcc_bus_rsp_s;

    typedef struct packed {
        logic [1:0] channel;
        logic       sampleHold;
        logic       refGenEnable;
        logic [9:0] tapCode;
    } adcc_analog_s;

endpackage
`default_nettype wire

// file: rtl/adcc_sar.sv
`timescale 1ns/10ps
`default_nettype none
// Successive-approximation register with one-hot trial bit
module adcc_sar
    import adcc_pkg::*;
#(
    parameter int ResBits = 10
) (
    input  wire logic               clk,
    input  wire logic               rstN,
    input  wire logic               start,
    input  wire logic               decide,
    input  wire logic               compIn,
    output logic      [ResBits-1:0] tapCode,
    output logic      [ResBits-1:0] finalCode,
    output logic                    lastBit
);

    logic [ResBits-1:0] approx_q;
    logic [ResBits-1:0] trial_q;

    initial begin
        if (ResBits < 2 || ResBits > 16) begin
            $error("adcc_sar: ResBits must lie between 2 and 16");
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            approx_q <= '0;
            trial_q  <= '0;
        end else if (start) begin
            approx_q <= '0;
            trial_q  <= {1'b1, {(ResBits-1){1'b0}}};
        end else if (decide && trial_q != '0) begin
            if (compIn) begin
                approx_q <= approx_q | trial_q;
            end
            trial_q <= trial_q >> 1;
        end
    end

    // Tap is the decided bits plus the bit under trial
    assign tapCode   = approx_q | trial_q;
    assign finalCode = compIn ? (approx_q | trial_q) : approx_q;
    assign lastBit   = trial_q[0];

endmodule
`default_nettype wire

// file: rtl/adcc_top.sv
`timescale 1ns/10ps
`default_nettype none
module adcc_top
    import adcc_pkg::*;
#(
    parameter int ResBits = 10
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    input  wire adcc_bus_req_s busReq,
    output adcc_bus_rsp_s      busRsp,
    input  wire logic          compIn,
    output adcc_analog_s       analogCtl,
    output logic               convDoneIrq
);

    localparam int ResultBits = ResBits + RESULT_PAD_BITS;

    initial begin
        if (ResBits != 10) begin
            $error("adcc_top: the result layout serves a 10-bit converter only");
        end
    end

    // Reset release through two flops
    logic [1:0] rstSync_q;
    logic       rstN;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    assign rstN = rstSync_q[1];

    // Bus decode
    logic hitResult;
    logic hitMode;
    logic hitChannel;
    logic hitCmpMode;
    logic hitThreshold;
    logic needsWait;
    logic waitDone_q;
    logic accessDone;
    logic rdDone;
    logic wrDone;

    assign hitResult    = busReq.addr == ADDR_RESULT_LO || busReq.addr == ADDR_RESULT_HI;
    assign hitMode      = busReq.addr == ADDR_MODE;
    assign hitChannel   = busReq.addr == ADDR_CHANNEL;
    assign hitCmpMode   = busReq.addr == ADDR_CMP_MODE;
    assign hitThreshold = busReq.addr == ADDR_THRESHOLD;

    // Result reads and control writes stretch by one cycle
    assign needsWait = busReq.write ? (hitMode || hitChannel || hitCmpMode || hitThreshold)
                                    : hitResult;

    assign busRsp.waitCycle = busReq.sel && needsWait && !waitDone_q;
    assign accessDone       = busReq.sel && !busRsp.waitCycle;
    assign rdDone           = accessDone && !busReq.write;
    assign wrDone           = accessDone && busReq.write;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            waitDone_q <= 1'b0;
        end else begin
            waitDone_q <= busReq.sel && needsWait && !waitDone_q;
        end
    end

    // Control registers
    logic       modeWr;
    logic       channelWr;
    logic       cmpModeWr;
    logic       thresholdWr;
    logic       ctlWr;
    logic       run_q;
    logic [2:0] convTime_q;
    logic       refGen_q;
    logic [1:0] channel_q;
    logic       cmpEnable_q;
    logic       cmpPolarity_q;
    logic [7:0] threshold_q;
    logic       runNext;
    logic [2:0] convTimeNext;

    assign modeWr      = wrDone && hitMode;
    assign channelWr   = wrDone && hitChannel;
    assign cmpModeWr   = wrDone && hitCmpMode;
    assign thresholdWr = wrDone && hitThreshold;
    assign ctlWr       = modeWr || channelWr || cmpModeWr || thresholdWr;

    assign runNext      = modeWr ? busReq.wrData[MODE_RUN_BIT] : run_q;
    assign convTimeNext = modeWr ? busReq.wrData[MODE_TIME_LSB +: 3] : convTime_q;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            run_q      <= MODE_RESET[MODE_RUN_BIT];
            convTime_q <= MODE_RESET[MODE_TIME_LSB +: 3];
            refGen_q   <= MODE_RESET[MODE_REFGEN_BIT];
        end else if (modeWr) begin
            run_q      <= busReq.wrData[MODE_RUN_BIT];
            convTime_q <= busReq.wrData[MODE_TIME_LSB +: 3];
            refGen_q   <= busReq.wrData[MODE_REFGEN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            channel_q <= CHANNEL_RESET[1:0];
        end else if (channelWr) begin
            channel_q <= busReq.wrData[1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cmpEnable_q   <= CMP_MODE_RESET[CMP_ENABLE_BIT];
            cmpPolarity_q <= CMP_MODE_RESET[CMP_POLARITY_BIT];
        end else if (cmpModeWr) begin
            cmpEnable_q   <= busReq.wrData[CMP_ENABLE_BIT];
            cmpPolarity_q <= busReq.wrData[CMP_POLARITY_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            threshold_q <= THRESHOLD_RESET;
        end else if (thresholdWr) begin
            threshold_q <= busReq.wrData;
        end
    end

    // Slot length per time-select code; prohibited codes fall back to the longest
    logic [7:0] slotCycles;

    always_comb begin
        unique case (convTimeNext)
            TIME_288: slotCycles = SLOT_CYC_T0;
            TIME_240: slotCycles = SLOT_CYC_T1;
            TIME_192: slotCycles = SLOT_CYC_T2;
            TIME_144: slotCycles = SLOT_CYC_T4;
            TIME_120: slotCycles = SLOT_CYC_T5;
            TIME_96:  slotCycles = SLOT_CYC_T6;
            default:  slotCycles = SLOT_CYC_T0;
        endcase
    end

    // Slot divider: one-cycle tick at the end of every slot
    adcc_state_e state_q;
    logic [7:0]  slotCnt_q;
    logic        slotTick;
    logic        sampleSlot_q;

    assign slotTick = (state_q != ST_IDLE) && (slotCnt_q == 8'h00);

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            slotCnt_q <= 8'h00;
        end else if (ctlWr || state_q == ST_IDLE || slotTick) begin
            slotCnt_q <= slotCycles - 8'h01;
        end else begin
            slotCnt_q <= slotCnt_q - 8'h01;
        end
    end

    // Sequencer
    logic sarStart;
    logic sarDecide;
    logic sarLast;
    logic convEnd;
    logic [ResBits-1:0] sarTap;
    logic [ResBits-1:0] sarFinal;

    assign sarStart  = (state_q == ST_SAMPLE) && slotTick && sampleSlot_q && !ctlWr;
    assign sarDecide = (state_q == ST_CONVERT) && slotTick && !ctlWr;
    // A control write in the end cycle suppresses the result and the interrupt
    assign convEnd   = sarDecide && sarLast;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_q      <= ST_IDLE;
            sampleSlot_q <= 1'b0;
        end else if (ctlWr) begin
            state_q      <= runNext ? ST_SAMPLE : ST_IDLE;
            sampleSlot_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (run_q) begin
                        state_q <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (slotTick) begin
                        sampleSlot_q <= ~sampleSlot_q;
                        if (sampleSlot_q) begin
                            state_q <= ST_CONVERT;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (convEnd) begin
                        state_q <= ST_SAMPLE;
                    end
                end
            endcase
        end
    end

    adcc_sar #(
        .ResBits   (ResBits)
    ) uSar (
        .clk       (clk_sys),
        .rstN      (rstN),
        .start     (sarStart),
        .decide    (sarDecide),
        .compIn    (compIn),
        .tapCode   (sarTap),
        .finalCode (sarFinal),
        .lastBit   (sarLast)
    );

    // Result register: holds no reset value, so it reads undefined until the first conversion
    logic [ResBits-1:0] result_q;

    always_ff @(posedge clk_sys) begin
        if (convEnd) begin
            result_q <= sarFinal;
        end
    end

    logic [ResultBits-1:0] resultWord;

    assign resultWord = {result_q, {RESULT_PAD_BITS{1'b0}}};

    // Threshold qualification of the done interrupt
    logic cmpHit;
    logic irqQualify;

    assign cmpHit     = cmpPolarity_q ? (sarFinal[ResBits-1 -: 8] <  threshold_q)
                                      : (sarFinal[ResBits-1 -: 8] >= threshold_q);
    assign irqQualify = !cmpEnable_q || cmpHit;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            convDoneIrq <= 1'b0;
        end else begin
            convDoneIrq <= convEnd && irqQualify;
        end
    end

    // Read path; a read in the end cycle takes the old result
    logic [15:0] rdData_q;
    logic        rdValid_q;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdData_q  <= 16'h0000;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= rdDone;
            if (rdDone) begin
                if (busReq.addr == ADDR_RESULT_LO && busReq.wide) begin
                    rdData_q <= resultWord;
                end else if (busReq.addr == ADDR_RESULT_LO) begin
                    rdData_q <= {8'h00, resultWord[7:0]};
                end else if (busReq.addr == ADDR_RESULT_HI) begin
                    rdData_q <= {8'h00, resultWord[15:8]};
                end else if (hitMode) begin
                    rdData_q <= {8'h00, run_q, 1'b0, convTime_q, 2'h0, refGen_q};
                end else if (hitChannel) begin
                    rdData_q <= {14'h0000, channel_q};
                end else if (hitCmpMode) begin
                    rdData_q <= {8'h00, cmpEnable_q, cmpPolarity_q, 6'h00};
                end else if (hitThreshold) begin
                    rdData_q <= {8'h00, threshold_q};
                end else begin
                    rdData_q <= 16'h0000;
                end
            end
        end
    end

    assign busRsp.rdData  = rdData_q;
    assign busRsp.rdValid = rdValid_q;

    // Analog side
    assign analogCtl.channel      = channel_q;
    assign analogCtl.sampleHold   = (state_q == ST_SAMPLE);
    assign analogCtl.refGenEnable = refGen_q;
    assign analogCtl.tapCode      = (state_q == ST_CONVERT) ? sarTap : '0;

endmodule
`default_nettype wire

// file: tb/adcc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adcc_monitor
    import adcc_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          rst_b,
    input wire adcc_bus_req_s busReq,
    input wire adcc_bus_rsp_s busRsp,
    input wire logic          compIn,
    input wire adcc_analog_s  analogCtl,
    input wire logic          convDoneIrq
);
    logic       wrTaken;
    logic       ctlAddr;
    logic [7:0] cmpQ;
    logic [7:0] thrQ;
    logic [9:0] codeQ;
    logic [9:0] tap;
    logic [9:0] lsb;
    assign tap = analogCtl.tapCode;
    assign lsb = tap & (~tap + 10'h001);
    assign ctlAddr = busReq.addr[15:2] == ADDR_MODE[15:2];
    assign wrTaken = busReq.sel && busReq.write && !busRsp.waitCycle;
    // Shadow copies of the compare settings as written over the bus
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmpQ <= 8'h00;
            thrQ <= 8'h00;
        end else if (wrTaken && busReq.addr == ADDR_CMP_MODE) begin
            cmpQ <= busReq.wrData;
        end else if (wrTaken && busReq.addr == ADDR_THRESHOLD) begin
            thrQ <= busReq.wrData;
        end
    end
    // Code of the conversion that is finishing, last bit from the comparator
    always_ff @(posedge clk_sys) begin
        if (tap[0]) begin
            codeQ <= {tap[9:1], compIn};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_irqPulse;
        convDoneIrq |=> !convDoneIrq;
    endproperty
    a_irqPulse: assert property (p_irqPulse) else $error("irq longer than one cycle");
    property p_readWait;
        $rose(busReq.sel) && !busReq.write && busReq.addr[15:1] == ADDR_RESULT_LO[15:1] |-> busRsp.waitCycle;
    endproperty
    a_readWait: assert property (p_readWait) else $error("result read without wait");
    property p_writeWait;
        $rose(busReq.sel) && busReq.write && ctlAddr |-> busRsp.waitCycle ##1 !busRsp.waitCycle;
    endproperty
    a_writeWait: assert property (p_writeWait) else $error("control write wait wrong");
    property p_writeNoIrq;
        wrTaken && ctlAddr |=> !convDoneIrq;
    endproperty
    a_writeNoIrq: assert property (p_writeNoIrq) else $error("irq after control write");
    property p_resultPad;
        busReq.sel && !busReq.write && busReq.wide && !busRsp.waitCycle && busReq.addr == ADDR_RESULT_LO
            |=> busRsp.rdValid && busRsp.rdData[5:0] == 6'h00;
    endproperty
    a_resultPad: assert property (p_resultPad) else $error("result low bits not zero");
    property p_channel;
        wrTaken && busReq.addr == ADDR_CHANNEL |=> analogCtl.channel == $past(busReq.wrData[1:0]);
    endproperty
    a_channel: assert property (p_channel) else $error("channel not applied");
    property p_refGen;
        wrTaken && busReq.addr == ADDR_MODE |=> analogCtl.refGenEnable == $past(busReq.wrData[0]);
    endproperty
    a_refGen: assert property (p_refGen) else $error("generator enable not applied");
    property p_firstTap;
        $past(tap) == 10'h000 && tap != 10'h000 |-> tap == 10'h200;
    endproperty
    a_firstTap: assert property (p_firstTap) else $error("first tap not half scale");
    property p_nextTap;
        $past(tap) != 10'h000 && tap != 10'h000 && tap != $past(tap) |-> tap == (($past(tap) & ~$past(lsb))
            | ($past(compIn) ? $past(lsb) : 10'h000) | ($past(lsb) >> 1));
    endproperty
    a_nextTap: assert property (p_nextTap) else $error("tap step wrong");
    property p_irqGate;
        convDoneIrq |-> !cmpQ[7] || (cmpQ[6] ? codeQ[9:2] < thrQ : codeQ[9:2] >= thrQ);
    endproperty
    a_irqGate: assert property (p_irqGate) else $error("irq against compare");
    property p_backToBack;
        convDoneIrq |-> analogCtl.sampleHold;
    endproperty
    a_backToBack: assert property (p_backToBack) else $error("no new sample after end");
endmodule
bind adcc_top adcc_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b), .busReq(busReq), .busRsp(busRsp),
    .compIn(compIn), .analogCtl(analogCtl), .convDoneIrq(convDoneIrq));
`default_nettype wire

// file: tb/adcc_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module adcc_analog_model
    import adcc_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire adcc_analog_s analogCtl,
    input  wire logic [9:0]   level [4],
    output logic              compIn
);
    logic [9:0] held;
    // Hold stage follows the chosen input only while sampling
    always @(posedge clk_sys) begin
        if (analogCtl.sampleHold) begin
            held <= level[analogCtl.channel];
        end
    end
    assign compIn = held >= analogCtl.tapCode;
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
    import adcc_pkg::*;
;
    logic          clk_sys = 1'b0;
    logic          rst_b = 1'b0;
    adcc_bus_req_s busReq = '0;
    adcc_bus_rsp_s busRsp;
    logic          compIn;
    adcc_analog_s  analogCtl;
    logic          convDoneIrq;
    logic [9:0]    level [4] = '{default: 10'h000};
    int            n_fail = 0;
    int            check_count = 0;
    // Reference generator settling, 14 us at 200 MHz
    localparam int StabCycles = 2800;
    always #2.5 clk_sys = ~clk_sys;
    adcc_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .busReq(busReq), .busRsp(busRsp), .compIn(compIn),
        .analogCtl(analogCtl), .convDoneIrq(convDoneIrq));
    adcc_analog_model u_ana (.clk_sys(clk_sys), .analogCtl(analogCtl), .level(level), .compIn(compIn));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic access(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d,
                          output logic [15:0] q);
        int i;
        q = 16'h0000;
        @(posedge clk_sys);
        busReq <= '{1'b1, w, wd, a, d};
        for (i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            if (busRsp.waitCycle === 1'b0) break;
        end
        if (i == 8) begin
            n_fail++;
            complete_run();
        end
        @(posedge clk_sys);
        busReq.sel <= 1'b0;
        if (!w) begin
            @(negedge clk_sys);
            q = busRsp.rdData;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [15:0] q;
        access(1'b1, 1'b0, a, d, q);
    endtask
    task automatic rd(input logic [15:0] a, input logic wd, output logic [15:0] q);
        access(1'b0, wd, a, 8'h00, q);
    endtask
    task automatic waitIrq(input int lim, output int n);
        for (n = 1; n <= lim; n++) begin
            @(negedge clk_sys);
            if (convDoneIrq === 1'b1) return;
        end
    endtask
    function automatic int perOf(input logic [2:0] c);
        case (c)
            3'h1: return 240;
            3'h2: return 192;
            3'h4: return 144;
            3'h5: return 120;
            3'h6: return 96;
            default: return 288;
        endcase
    endfunction
    function automatic logic expIrq(input logic pol, input logic [7:0] up, input logic [7:0] thr);
        return pol ? (up < thr) : (up >= thr);
    endfunction
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        complete_run();
    end
    initial begin
        logic [15:0] q;
        logic [15:0] regs [5];
        logic [9:0]  lv;
        logic [7:0]  t;
        logic [7:0]  up;
        logic [1:0]  ch;
        int          n;
        int          k;
        regs = '{ADDR_MODE, ADDR_CHANNEL, ADDR_CMP_MODE, ADDR_THRESHOLD, 16'hff30};
        void'($urandom(32'heb14));
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (k = 0; k < 5; k++) begin
            rd(regs[k], 1'b0, q);
            cmpVal(q, 16'h0000);
        end
        $display("test reset done");
        wr(ADDR_MODE, 8'h01);
        repeat (StabCycles) @(posedge clk_sys);
        for (k = 0; k < 4; k++) begin
            level[k] <= 10'($urandom);
        end
        for (k = 0; k < 8; k++) begin
            ch = 2'(k);
            lv = 10'($urandom);
            @(posedge clk_sys);
            level[ch] <= lv;
            wr(ADDR_CHANNEL, {6'h00, ch});
            wr(ADDR_MODE, {1'b1, 1'b0, 3'(k), 2'b00, 1'b1});
            waitIrq(1000, n);
            cmpVal(16'(n <= 1000), 16'h0001);
            waitIrq(400, n);
            cmpVal(16'(n), 16'(perOf(3'(k))));
            rd(ADDR_RESULT_LO, 1'b1, q);
            cmpVal(q, {lv, 6'h00});
            rd(ADDR_RESULT_HI, 1'b0, q);
            cmpVal(q, {8'h00, lv[9:2]});
            rd(ADDR_RESULT_LO, 1'b0, q);
            cmpVal(q, {8'h00, lv[1:0], 6'h00});
            rd(ADDR_CHANNEL, 1'b0, q);
            cmpVal(q, {14'h0000, ch});
        end
        $display("test conversion done");
        for (k = 0; k < 4; k++) begin
            t = 8'($urandom_range(1, 254));
            up = k[0] ? t : t - 8'h01;
            @(posedge clk_sys);
            level[0] <= {up, 2'($urandom)};
            wr(ADDR_CHANNEL, 8'h00);
            wr(ADDR_THRESHOLD, t);
            wr(ADDR_CMP_MODE, {1'b1, k[1], 6'h00});
            waitIrq(300, n);
            cmpVal(16'(n <= 300), 16'(expIrq(k[1], up, t)));
        end
        wr(ADDR_CMP_MODE, 8'h00);
        waitIrq(300, n);
        cmpVal(16'(n <= 300), 16'h0001);
        $display("test compare done");
        wr(ADDR_MODE, 8'hb1);
        for (k = 0; k < 5; k++) begin
            waitIrq(60, n);
            cmpVal(16'(n <= 60), 16'h0000);
            wr(ADDR_THRESHOLD, 8'h00);
        end
        waitIrq(100, n);
        cmpVal(16'(n <= 100), 16'h0001);
        $display("test abort done");
        waitIrq(40, n);
        wr(ADDR_MODE, 8'h01);
        waitIrq(300, n);
        cmpVal(16'(n <= 300), 16'h0000);
        cmpVal(16'(analogCtl.sampleHold), 16'h0000);
        wr(ADDR_MODE, 8'hb1);
        waitIrq(100, n);
        cmpVal(16'(n <= 100), 16'h0001);
        $display("test stop done");
        complete_run();
    end
endmodule
`default_nettype wire
